// ---- verilog/uhde_engine.sv ----
`timescale 1ns/10ps
`include "uhde_regs.svh"
module uhde_engine #(
  parameter int AW = 8
) (
  input  logic                 clk,
  input  logic                 resetn,
  input  logic                 wb_cyc_i,
  input  logic                 wb_stb_i,
  input  logic                 wb_we_i,
  input  logic [11:0]          wb_adr_i,
  input  logic [3:0]           wb_sel_i,
  input  logic [31:0]          wb_dat_i,
  output logic [31:0]          wb_dat_o,
  output logic                 wb_ack_o,
  output logic                 txnReq,
  output uhde_pkg::uhde_dir_t  txnDir,
  output logic [6:0]           txnAddr,
  output logic [3:0]           txnEp,
  output logic                 txnLowSpeed,
  output logic                 txnIso,
  output logic                 txnToggle,
  output uhde_pkg::uhde_len_t  txnMaxLen,
  output uhde_pkg::uhde_len_t  txnReqLen,
  input  logic                 txnDone,
  input  uhde_pkg::uhde_len_t  txnCount,
  input  logic                 txnToggleOut,
  input  logic                 errCrc,
  input  logic                 errStuff,
  input  logic                 errToggle,
  input  logic                 gotStall,
  input  logic                 noResponse,
  input  logic                 pidCheckErr,
  input  logic                 badPid,
  input  logic                 storeTooSlow,
  input  logic                 fetchTooSlow,
  input  logic [AW-1:0]        payIdx,
  input  logic                 payWe,
  input  logic [31:0]          payWdata,
  output logic [31:0]          payRdata
);
  import uhde_pkg::*;

  typedef struct packed {
    uhde_state_t st;
    logic [AW-1:0] ptr;
    logic [AW-1:0] base;
    logic [31:0]   w0;
    logic [31:0]   w1;
    uhde_len_t     cnt;
    logic          tog;
    uhde_code_t    code;
    uhde_code_t    lastCode;
    logic          done;
    logic [7:0]    hdrCnt;
    logic          ack;
    logic          ramRd;
    logic [31:0]   dat;
  } uhde_eng_t;

  uhde_eng_t s_r, s_nxt;
  logic [31:0] mem [2**AW];
  logic [31:0] ramQ;
  logic [AW-1:0] ramAddr;
  logic        ramWe;
  logic [3:0]  ramBe;
  logic [31:0] ramWdata;
  logic        live, tail, hTog, hLow, hIso;
  logic [3:0]  hEp;
  logic [6:0]  hAddr;
  uhde_len_t   hMax, hReq;
  uhde_dir_t   hDir;
  uhde_code_t  evCode;
  logic        acc, isRam;
  logic [AW:0] nxtPtr;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // word index of the record after this one; msb flags a run past the end
  function automatic logic [AW:0] nextPtr(input logic [AW-1:0] p, input uhde_len_t len);
    logic [AW+1:0] sum;
    sum = (AW+2)'(p) + (AW+2)'(`UHDE_HDR_WORDS) + (AW+2)'((11'(len) + 11'h003) >> 2);
    nextPtr = {|sum[AW+1:AW], sum[AW-1:0]};
  endfunction : nextPtr

  uhde_hdr_decode u_dec (
    .w0       (s_r.w0),
    .w1       (s_r.w1),
    .live     (live),
    .tail     (tail),
    .tog      (hTog),
    .lowSpeed (hLow),
    .ep       (hEp),
    .maxLen   (hMax),
    .reqLen   (hReq),
    .dir      (hDir),
    .iso      (hIso),
    .faddr    (hAddr)
  );

  uhde_result_enc u_enc (
    .isIn         (hDir == DIR_IN),
    .errCrc       (errCrc),
    .errStuff     (errStuff),
    .errToggle    (errToggle),
    .gotStall     (gotStall),
    .noResponse   (noResponse),
    .pidCheckErr  (pidCheckErr),
    .badPid       (badPid),
    .storeTooSlow (storeTooSlow),
    .fetchTooSlow (fetchTooSlow),
    .count        (txnCount),
    .reqLen       (hReq),
    .maxLen       (hMax),
    .code         (evCode)
  );

  assign acc    = wb_cyc_i & wb_stb_i & ~s_r.ack;
  assign isRam  = wb_adr_i[`UHDE_RAM_BIT];
  assign nxtPtr = nextPtr(s_r.ptr, hReq);

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  // bus, engine and buffer port share one process so the buffer has one owner per cycle
  always_comb begin
    s_nxt    = s_r;
    s_nxt.ack = 1'b0;
    ramAddr  = s_r.ptr;
    ramWe    = 1'b0;
    ramBe    = 4'hf;
    ramWdata = wb_dat_i;
    // buffer window only while idle: a walk in flight must not see half-written records
    if (acc && isRam && s_r.st == S_IDLE) begin
      s_nxt.ack   = 1'b1;
      s_nxt.ramRd = ~wb_we_i;
      ramAddr     = wb_adr_i[AW+1:2];
      ramWe       = wb_we_i;
      ramBe       = wb_sel_i;
    end else if (acc && !isRam) begin
      s_nxt.ack   = 1'b1;
      s_nxt.ramRd = 1'b0;
      s_nxt.dat   = 32'h0000_0000;
      if (wb_we_i && wb_sel_i[0]) begin
        unique case (wb_adr_i)
          `UHDE_CTRL_OFS: if (wb_dat_i[`UHDE_GO_BIT] && s_r.st == S_IDLE) begin
            s_nxt.st     = S_RDA;
            s_nxt.ptr    = s_r.base;
            s_nxt.hdrCnt = 8'h00;
          end
          `UHDE_STAT_OFS: if (wb_dat_i[`UHDE_DONE_BIT]) s_nxt.done = 1'b0;
          `UHDE_BASE_OFS: s_nxt.base = wb_dat_i[AW-1:0];
          default: ;
        endcase
      end else if (!wb_we_i) begin
        unique case (wb_adr_i)
          `UHDE_STAT_OFS: begin
            s_nxt.dat[`UHDE_BUSY_BIT]     = (s_r.st != S_IDLE);
            s_nxt.dat[`UHDE_DONE_BIT]     = s_r.done;
            s_nxt.dat[`UHDE_LAST_LSB +: 4] = s_r.lastCode;
          end
          `UHDE_BASE_OFS:  s_nxt.dat[AW-1:0] = s_r.base;
          `UHDE_COUNT_OFS: s_nxt.dat[7:0]    = s_r.hdrCnt;
          default: ;
        endcase
      end
    end
    unique case (s_r.st)
      S_IDLE: ;
      S_RDA: s_nxt.st = S_RDB;
      S_RDB: begin
        ramAddr   = s_r.ptr + AW'(1);
        s_nxt.w0  = ramQ;
        s_nxt.st  = S_RDC;
      end
      S_RDC: begin
        s_nxt.w1 = ramQ;
        s_nxt.st = S_CHECK;
      end
      S_CHECK: begin
        if (!live) begin
          s_nxt.st = S_NEXT;
        end else if (hDir == DIR_RSVD) begin
          s_nxt.cnt  = 10'h000;
          s_nxt.tog  = hTog;
          s_nxt.code = RC_BAD_PID;
          s_nxt.st   = S_WRB;
        end else begin
          s_nxt.st = S_XFER;
        end
      end
      S_XFER: begin
        ramAddr  = s_r.ptr + AW'(`UHDE_HDR_WORDS) + payIdx;
        ramWe    = payWe;
        ramWdata = payWdata;
        if (txnDone) begin
          s_nxt.cnt  = txnCount;
          s_nxt.tog  = txnToggleOut;
          s_nxt.code = evCode;
          s_nxt.st   = S_WRB;
        end
      end
      S_WRB: begin
        ramWe    = 1'b1;
        ramWdata = s_r.w0;
        ramWdata[`UHDE_CNT_LSB +: 10] = s_r.cnt;
        ramWdata[`UHDE_CODE_LSB +: 4] = s_r.code;
        ramWdata[`UHDE_TOG_BIT]       = s_r.tog;
        ramWdata[`UHDE_LIVE_BIT]      = 1'b0;
        s_nxt.lastCode = s_r.code;
        s_nxt.hdrCnt   = s_r.hdrCnt + 8'h01;
        s_nxt.st       = S_NEXT;
      end
      S_NEXT: begin
        if (tail || nxtPtr[AW]) begin
          s_nxt.st = S_DONE;
        end else begin
          s_nxt.ptr = nxtPtr[AW-1:0];
          s_nxt.st  = S_RDA;
        end
      end
      // done set here wins over a clear in the same cycle
      S_DONE: begin
        s_nxt.done = 1'b1;
        s_nxt.st   = S_IDLE;
      end
      default: s_nxt.st = S_IDLE;
    endcase
  end

  // ----------------------------------------
  // state and buffer storage
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) s_r <= '0;
    else s_r <= s_nxt;
  end

  // buffer read data lags the address by one cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) ramQ <= 32'h0000_0000;
    else ramQ <= mem[ramAddr];
  end

  always_ff @(posedge clk) begin
    for (int b = 0; b < 4; b++) begin
      if (ramWe && ramBe[b]) mem[ramAddr][8*b +: 8] <= ramWdata[8*b +: 8];
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign wb_ack_o    = s_r.ack;
  assign wb_dat_o    = s_r.ramRd ? ramQ : s_r.dat;
  assign payRdata    = ramQ;
  assign txnReq      = (s_r.st == S_XFER);
  assign txnDir      = hDir;
  assign txnAddr     = hAddr;
  assign txnEp       = hEp;
  assign txnLowSpeed = hLow;
  assign txnIso      = hIso;
  assign txnToggle   = hTog;
  assign txnMaxLen   = hMax;
  assign txnReqLen   = hReq;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic xDone, anyErr;
  assign xDone  = (s_r.st == S_XFER) && txnDone;
  assign anyErr = gotStall | noResponse | pidCheckErr | badPid | errCrc | errStuff
                | errToggle | storeTooSlow | fetchTooSlow;

  property p_count_wb;
    xDone |=> ramWe && ramWdata[`UHDE_CNT_LSB +: 10] == $past(txnCount);
  endproperty
  a_count_wb: assert property (p_count_wb) else $error("count not written back");

  property p_live_clr;
    (s_r.st == S_WRB) |-> ramWe && !ramWdata[`UHDE_LIVE_BIT] && ramAddr == s_r.ptr;
  endproperty
  a_live_clr: assert property (p_live_clr) else $error("live flag not cleared");

  // top three code bits 101 cover exactly the two reserved codes
  property p_no_rsvd;
    (s_r.st == S_WRB) |-> !(ramWdata[`UHDE_CODE_LSB + 1 +: 3] == 3'h5);
  endproperty
  a_no_rsvd: assert property (p_no_rsvd) else $error("reserved result code written");

  property p_clean;
    xDone && !anyErr && (hDir != DIR_IN || (txnCount == hReq && txnCount <= hMax))
      |=> ramWdata[`UHDE_CODE_LSB +: 4] == 4'h0;
  endproperty
  a_clean: assert property (p_clean) else $error("clean finish not coded zero");

  property p_stall;
    xDone && gotStall |=> ramWdata[`UHDE_CODE_LSB +: 4] == 4'h4;
  endproperty
  a_stall: assert property (p_stall) else $error("stall not coded");

  property p_noresp;
    xDone && noResponse && !gotStall |=> ramWdata[`UHDE_CODE_LSB +: 4] == 4'h5;
  endproperty
  a_noresp: assert property (p_noresp) else $error("no response not coded");

  property p_issue;
    (s_r.st == S_CHECK) && live && hDir != DIR_RSVD
      |=> txnReq && txnDir == $past(hDir) && txnReqLen == $past(hReq);
  endproperty
  a_issue: assert property (p_issue) else $error("transaction not issued from header");

  property p_walk;
    (s_r.st == S_NEXT) && !tail && !nxtPtr[AW]
      |=> s_r.st == S_RDA && s_r.ptr == $past(nxtPtr[AW-1:0]) ##3 s_r.st == S_CHECK;
  endproperty
  a_walk: assert property (p_walk) else $error("record walk misaligned");

  property p_skip;
    (s_r.st == S_CHECK) && !live |=> !txnReq && s_r.st == S_NEXT;
  endproperty
  a_skip: assert property (p_skip) else $error("dead header not skipped");
endmodule : uhde_engine

// ---- pkg/uhde_regs.svh ----
`ifndef UHDE_REGS_SVH
`define UHDE_REGS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define UHDE_CTRL_OFS   12'h000
`define UHDE_STAT_OFS   12'h004
`define UHDE_BASE_OFS   12'h008
`define UHDE_COUNT_OFS  12'h00c
`define UHDE_RAM_BIT    10
// ----------------------------------------
// control and status bits
// ----------------------------------------
`define UHDE_GO_BIT     0
`define UHDE_BUSY_BIT   0
`define UHDE_DONE_BIT   1
`define UHDE_LAST_LSB   4
// ----------------------------------------
// header layout, two little-endian words
// ----------------------------------------
`define UHDE_HDR_WORDS  2
`define UHDE_CNT_LSB    0
`define UHDE_TOG_BIT    10
`define UHDE_LIVE_BIT   11
`define UHDE_CODE_LSB   12
`define UHDE_MAXL_LSB   16
`define UHDE_SPD_BIT    26
`define UHDE_TAIL_BIT   27
`define UHDE_EP_LSB     28
`define UHDE_REQ_LSB    0
`define UHDE_DIR_LSB    10
`define UHDE_FADDR_LSB  16
`define UHDE_ISO_BIT    23
`endif

// ---- pkg/uhde_pkg.sv ----
package uhde_pkg;
  // ----------------------------------------
  // shared types
  // ----------------------------------------
  typedef logic [9:0] uhde_len_t;

  typedef enum logic [1:0] {
    DIR_SETUP = 2'b00,
    DIR_OUT   = 2'b01,
    DIR_IN    = 2'b10,
    DIR_RSVD  = 2'b11
  } uhde_dir_t;

  // 1010 and 1011 are deliberately absent
  typedef enum logic [3:0] {
    RC_OK                = 4'b0000,
    RC_CRC               = 4'b0001,
    RC_STUFF             = 4'b0010,
    RC_TOGGLE_ERROR      = 4'b0011,
    RC_STALL             = 4'b0100,
    RC_NO_RESPONSE       = 4'b0101,
    RC_PID_CHECK_ERROR   = 4'b0110,
    RC_BAD_PID           = 4'b0111,
    RC_RX_LENGTH_OVERRUN = 4'b1000,
    RC_RX_SHORT_PACKET   = 4'b1001,
    RC_STORE_TOO_SLOW    = 4'b1100,
    RC_FETCH_TOO_SLOW    = 4'b1101
  } uhde_code_t;

  typedef enum logic [3:0] {
    S_IDLE  = 4'b0000,
    S_RDA   = 4'b0001,
    S_RDB   = 4'b0010,
    S_RDC   = 4'b0011,
    S_CHECK = 4'b0100,
    S_XFER  = 4'b0101,
    S_WRB   = 4'b0110,
    S_NEXT  = 4'b0111,
    S_DONE  = 4'b1000
  } uhde_state_t;
endpackage : uhde_pkg

// ---- verilog/uhde_hdr_decode.sv ----
`timescale 1ns/10ps
`include "uhde_regs.svh"
module uhde_hdr_decode (
  input  logic [31:0]         w0,
  input  logic [31:0]         w1,
  output logic                live,
  output logic                tail,
  output logic                tog,
  output logic                lowSpeed,
  output logic [3:0]          ep,
  output uhde_pkg::uhde_len_t maxLen,
  output uhde_pkg::uhde_len_t reqLen,
  output uhde_pkg::uhde_dir_t dir,
  output logic                iso,
  output logic [6:0]          faddr
);
  import uhde_pkg::*;
  // ----------------------------------------
  // field split of the eight header bytes
  // ----------------------------------------
  // word0 fields, then word1 fields from reqLen on
  assign live     = w0[`UHDE_LIVE_BIT];
  assign tog      = w0[`UHDE_TOG_BIT];
  assign maxLen   = w0[`UHDE_MAXL_LSB +: 10];
  assign lowSpeed = w0[`UHDE_SPD_BIT];
  assign tail     = w0[`UHDE_TAIL_BIT];
  assign ep       = w0[`UHDE_EP_LSB +: 4];
  assign reqLen   = w1[`UHDE_REQ_LSB +: 10];
  assign dir      = uhde_dir_t'(w1[`UHDE_DIR_LSB +: 2]);
  assign iso      = w1[`UHDE_ISO_BIT];
  assign faddr    = w1[`UHDE_FADDR_LSB +: 7];
endmodule : uhde_hdr_decode

// ---- verilog/uhde_result_enc.sv ----
`timescale 1ns/10ps
module uhde_result_enc (
  input  logic                isIn,
  input  logic                errCrc,
  input  logic                errStuff,
  input  logic                errToggle,
  input  logic                gotStall,
  input  logic                noResponse,
  input  logic                pidCheckErr,
  input  logic                badPid,
  input  logic                storeTooSlow,
  input  logic                fetchTooSlow,
  input  uhde_pkg::uhde_len_t count,
  input  uhde_pkg::uhde_len_t reqLen,
  input  uhde_pkg::uhde_len_t maxLen,
  output uhde_pkg::uhde_code_t code
);
  import uhde_pkg::*;
  // ----------------------------------------
  // one code per header, worst event first
  // ----------------------------------------
  // handshake faults outrank data faults, the packet content is moot then
  // no branch yields 1010 or 1011
  always_comb begin
    code = RC_OK;
    if (gotStall) code = RC_STALL;
    else if (noResponse) code = RC_NO_RESPONSE;
    else if (pidCheckErr) code = RC_PID_CHECK_ERROR;
    else if (badPid) code = RC_BAD_PID;
    else if (errCrc) code = RC_CRC;
    else if (errStuff) code = RC_STUFF;
    else if (errToggle) code = RC_TOGGLE_ERROR;
    else if (isIn && storeTooSlow) code = RC_STORE_TOO_SLOW;
    else if (!isIn && fetchTooSlow) code = RC_FETCH_TOO_SLOW;
    else if (isIn && (count > maxLen || count > reqLen)) code = RC_RX_LENGTH_OVERRUN;
    else if (isIn && count < reqLen && count < maxLen) code = RC_RX_SHORT_PACKET;
    else code = RC_OK;
  end
endmodule : uhde_result_enc

// ---- verification/uhde_usb_model.sv ----
`timescale 1ns/10ps
// ------------------------------------
// far-side usb engine model
// ------------------------------------
module uhde_usb_model (
  input  logic                clk,
  input  logic                resetn,
  input  logic                txnReq,
  input  logic                txnToggle,
  input  logic [3:0]          cfgDelay,
  input  uhde_pkg::uhde_len_t cfgCount,
  input  logic [8:0]          cfgErr,
  output logic                txnDone,
  output uhde_pkg::uhde_len_t txnCount,
  output logic                txnToggleOut,
  output logic [8:0]          errs,
  output logic [7:0]          payIdx,
  output logic                payWe,
  output logic [31:0]         payWdata
);
  import uhde_pkg::*;
  logic [3:0] waitCnt_r;
  logic       seen_r;
  // one payload word on the second request cycle, then done after the chosen delay
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txnDone   <= 1'b0;
      payWe     <= 1'b0;
      seen_r    <= 1'b0;
      waitCnt_r <= 4'h0;
    end else if (txnReq && !txnDone) begin
      seen_r <= 1'b1;
      payWe  <= !seen_r;
      if (seen_r && waitCnt_r == cfgDelay) txnDone <= 1'b1;
      else if (seen_r) waitCnt_r <= waitCnt_r + 4'h1;
    end else begin
      txnDone   <= 1'b0;
      payWe     <= 1'b0;
      seen_r    <= 1'b0;
      waitCnt_r <= 4'h0;
    end
  end
  // results only hold with the done pulse; inverted otherwise so stale values show
  assign txnCount     = txnDone ? cfgCount : ~cfgCount;
  assign errs         = txnDone ? cfgErr : ~cfgErr;
  assign txnToggleOut = txnDone ? ~txnToggle : txnToggle;
  assign payIdx       = payWe ? 8'h00 : 8'hff;
  assign payWdata     = payWe ? 32'hc0de_0001 : 32'h3f21_fffe;
endmodule : uhde_usb_model

// ---- verification/uhde_tb.sv ----
`timescale 1ns/10ps
module tb;
  import uhde_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
  logic [11:0] wbAdr = 12'h000;
  logic [31:0] wbDat = 32'h0000_0000, rdat, q, payWdata, payRd, capPay;
  logic [3:0] mDelay = 4'h0;
  logic [8:0] mErr = 9'h000, errs;
  uhde_len_t mCnt = 10'h000, txnCount, txnMaxLen, txnReqLen;
  uhde_dir_t txnDir, kDir;
  logic [6:0] txnAddr;
  logic [3:0] txnEp;
  logic [7:0] payIdx;
  logic txnReq, txnDone, txnTog, txnTogOut, txnLow, txnIso, payWe, reqPrev = 1'b0;
  logic [34:0] capFld;
  int fails = 0, nTests = 0, nReq = 0, k;
  always #25 clk = ~clk;
  uhde_engine #(.AW(8)) DUT (.clk(clk), .resetn(resetn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDat), .wb_dat_o(rdat),
    .wb_ack_o(wbAck), .txnReq(txnReq), .txnDir(txnDir), .txnAddr(txnAddr), .txnEp(txnEp),
    .txnLowSpeed(txnLow), .txnIso(txnIso), .txnToggle(txnTog), .txnMaxLen(txnMaxLen),
    .txnReqLen(txnReqLen), .txnDone(txnDone), .txnCount(txnCount),
    .txnToggleOut(txnTogOut), .errCrc(errs[0]), .errStuff(errs[1]), .errToggle(errs[2]),
    .gotStall(errs[3]), .noResponse(errs[4]), .pidCheckErr(errs[5]), .badPid(errs[6]),
    .storeTooSlow(errs[7]), .fetchTooSlow(errs[8]), .payIdx(payIdx), .payWe(payWe),
    .payWdata(payWdata), .payRdata(payRd));
  uhde_usb_model u_model (.clk(clk), .resetn(resetn), .txnReq(txnReq), .txnToggle(txnTog),
    .cfgDelay(mDelay), .cfgCount(mCnt), .cfgErr(mErr), .txnDone(txnDone),
    .txnCount(txnCount), .txnToggleOut(txnTogOut), .errs(errs), .payIdx(payIdx),
    .payWe(payWe), .payWdata(payWdata));
  // transaction fields sampled mid-cycle, where they are settled
  always @(negedge clk) begin
    if (txnReq && !reqPrev) nReq++;
    if (txnReq) capFld = {txnDir, txnAddr, txnEp, txnLow, txnIso, txnMaxLen, txnReqLen};
    if (txnReq && txnDone) capPay = payRd;
    reqPrev = txnReq;
  end
  // ------------------------------------
  // shared tasks
  // ------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [34:0] seen, input logic [34:0] exp);
    nTests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // classic cycle: held until ack is sampled, data taken at that edge
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe  <= w;
    wbAdr <= a;
    wbDat <= d;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (wbAck === 1'b1) break;
    end
    q = rdat;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (i == 100) begin
      fails++;
      report_and_stop();
    end
  endtask : wb
  function automatic logic [11:0] wa(input logic [7:0] w);
    return {2'b01, w, 2'b00};
  endfunction : wa
  function automatic logic [31:0] hdr0(input logic lv, tl, sp, input logic [3:0] ep,
                                       input uhde_len_t ml);
    return {ep, tl, sp, ml, 4'hf, lv, 1'b0, 10'h3ff};
  endfunction : hdr0
  function automatic logic [31:0] hdr1(input uhde_len_t rq, input uhde_dir_t d, input logic iso);
    return {8'h5a, iso, 7'h2b, 4'h0, d, rq};
  endfunction : hdr1
  // start at base and poll status until idle with done set
  task automatic run_walk(input logic [7:0] base);
    int i;
    wb(1'b1, 12'h008, {24'h00_0000, base});
    wb(1'b1, 12'h004, 32'h0000_0002);
    wb(1'b1, 12'h000, 32'h0000_0001);
    // poll bound keeps a walk far inside one 1 ms frame
    for (i = 0; i < 200; i++) begin
      wb(1'b0, 12'h004, 32'h0000_0000);
      if (q[1:0] === 2'b10) break;
    end
    if (i == 200) begin
      fails++;
      report_and_stop();
    end
  endtask : run_walk
  logic [3:0] codeTab [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hc, 4'hd,
                              4'h8, 4'h9};
  // ------------------------------------
  // main sequence
  // ------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    wb(1'b0, 12'h004, 32'h0000_0000);
    check("status", q, 32'h0000_0000);
    wb(1'b1, 12'h010, 32'hffff_ffff);
    wb(1'b0, 12'h010, 32'h0000_0000);
    check("unmapped", q, 32'h0000_0000);
    wb(1'b1, 12'h00c, 32'h0000_00ff);
    wb(1'b0, 12'h00c, 32'h0000_0000);
    check("count reg", q, 32'h0000_0000);
    $display("test registers done");
    for (k = 0; k < 12; k++) begin
      mErr   <= (k > 0 && k < 10) ? 9'h001 << (k - 1) : 9'h000;
      mCnt   <= (k == 10) ? 10'h009 : (k == 11) ? 10'h004 : 10'h008;
      mDelay <= k[3:0];
      // setup token on the stall case, so setup, out and in are all issued
      kDir = (k == 9) ? DIR_OUT : (k == 4) ? DIR_SETUP : DIR_IN;
      wb(1'b1, wa(8'h00), hdr0(1'b1, 1'b1, k[1], k[3:0], 10'h010));
      wb(1'b1, wa(8'h01), hdr1(10'h008, kDir, k[0]));
      run_walk(8'h00);
      check("last code", q[7:4], codeTab[k]);
      check("fields", capFld[34:20], {kDir, 7'h2b, k[3:0], k[1], k[0]});
      check("lengths", capFld[19:0], {10'h010, 10'h008});
      // idle index 255 wraps onto header word1, seen one cycle late
      if (k > 0) check("pay read", capPay, hdr1(10'h008, kDir, k[0]));
      wb(1'b0, wa(8'h00), 32'h0000_0000);
      check("word0", q, {k[3:0], 1'b1, k[1], 10'h010, codeTab[k], 2'b01, mCnt});
      check("moved", q[9:0], mCnt);
      check("code field", q[15:12], codeTab[k]);
      wb(1'b0, wa(8'h01), 32'h0000_0000);
      check("word1", q, hdr1(10'h008, kDir, k[0]));
      wb(1'b0, wa(8'h02), 32'h0000_0000);
      if (k != 9) check("payload", q, 32'hc0de_0001);
    end
    check("txn count", nReq, 12);
    $display("test result codes done");
    // skipped header, reserved direction at aligned next record
    wb(1'b1, wa(8'h08), hdr0(1'b0, 1'b0, 1'b0, 4'h1, 10'h008));
    wb(1'b1, wa(8'h09), hdr1(10'h004, DIR_IN, 1'b0));
    wb(1'b1, wa(8'h0b), hdr0(1'b1, 1'b1, 1'b0, 4'h3, 10'h008));
    wb(1'b1, wa(8'h0c), hdr1(10'h000, DIR_RSVD, 1'b0));
    run_walk(8'h08);
    check("rsvd code", q[7:4], 4'h7);
    check("no txn", nReq, 12);
    wb(1'b0, wa(8'h08), 32'h0000_0000);
    check("skipped", q, hdr0(1'b0, 1'b0, 1'b0, 4'h1, 10'h008));
    wb(1'b0, wa(8'h0b), 32'h0000_0000);
    check("rsvd word0", q & 32'hffff_fbff, 32'h3808_7000);
    wb(1'b0, 12'h00c, 32'h0000_0000);
    check("headers done", q, 32'h0000_0001);
    wb(1'b0, 12'h008, 32'h0000_0000);
    check("base", q, 32'h0000_0008);
    wb(1'b1, 12'h004, 32'h0000_0002);
    wb(1'b0, 12'h004, 32'h0000_0000);
    check("done cleared", q[1], 1'b0);
    $display("test skip and reserved done");
    report_and_stop();
  end
endmodule : tb
